// ---- src/aipd_defs.svh ----
`ifndef AIPD_DEFS_SVH
`define AIPD_DEFS_SVH

// ----------------------------------------
// record byte offsets
// ----------------------------------------
`define AIPD_OFF_IRQ 4'h0
`define AIPD_OFF_CONV 4'h1
`define AIPD_OFF_MODE0 4'h2
`define AIPD_OFF_MODE3 4'h5
`define AIPD_OFF_LIM0_UP 4'h6
`define AIPD_OFF_LIM0_LO 4'h8
`define AIPD_OFF_LIM2_UP 4'hA
`define AIPD_OFF_LIM2_LO 4'hC
`define AIPD_REC_LEN 4'hE

// ----------------------------------------
// field positions
// ----------------------------------------
`define AIPD_DIAG_BIT 6
`define AIPD_PROC_BIT 7
`define AIPD_IRQ_MASK 8'hC0
`define AIPD_RANGE_LSB 0
`define AIPD_TYPE_LSB 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define AIPD_RST_IRQ 8'h00
`define AIPD_RST_CONV 8'hAA
`define AIPD_RST_MODE 8'h19
`define AIPD_RST_UP 16'h7FFF
`define AIPD_RST_LO 16'h8000

// ----------------------------------------
// measuring type codes
// ----------------------------------------
`define AIPD_TYPE_VOLT 4'h1
`define AIPD_TYPE_CUR4 4'h2
`define AIPD_TYPE_CUR2 4'h3
`define AIPD_TYPE_RES4 4'h4

// ----------------------------------------
// count scaling
// ----------------------------------------
`define AIPD_NOM_CNT 16'd27648
`define AIPD_OVR_END 20'sd32511
`define AIPD_UND_BIP (-20'sd32512)
`define AIPD_UND_UNI (-20'sd4864)
`define AIPD_SAT_HI 16'h7FFF
`define AIPD_SAT_LO 16'h8000

// ----------------------------------------
// conversion times (us) and clock rate
// ----------------------------------------
`define AIPD_CLK_MHZ 125
`define AIPD_T400_US 2.5e3
`define AIPD_T60_US 16.6e3
`define AIPD_T50_US 20.0e3
`define AIPD_T10_US 100.0e3

`endif

// ---- src/aipd_pkg.sv ----
package aipd_pkg;

  // range class of a pair's type/range combination
  typedef enum logic [3:0] {
    AIPD_KIND_BAD = 4'h1,
    AIPD_KIND_BIP = 4'h2,
    AIPD_KIND_UNI = 4'h4,
    AIPD_KIND_RES = 4'h8
  } aipd_kind_t;

  // raw sample from the converter, full nominal scale = +/-2^16
  typedef struct packed {
    logic [2:0] ch;
    logic signed [17:0] raw;
  } aipd_sample_t;

  // scaled measurement word
  typedef struct packed {
    logic [2:0] ch;
    logic [15:0] value;
  } aipd_meas_t;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] conv;
    logic [3:0][7:0] mode;
    logic [3:0][15:0] lim;
    logic [7:0] rd_data;
    logic wr_reject;
    logic meas_valid;
    aipd_meas_t meas;
    logic proc_irq;
    logic [1:0] outside;
    logic [3:0][23:0] cnt;
    logic [3:0] tick;
  } aipd_state_t;

endpackage

// ---- src/aipd_top.sv ----
`timescale 1ns/1ps
`include "aipd_defs.svh"

// How it works
// - byte 0 bit6 diag, bit7 process enable
// - byte 1 two-bit conversion time per pair
// - bytes 2-5 pair mode, range low nibble
// - channel 0 upper and lower limit words
// - channel 2 upper and lower limit words
// - type 0001b voltage with listed range codes
// - bipolar ranges scale to plus/minus 27648
// - 1-5 V range scales 0..27648, -4864 under
// - type 0010b four-wire current range codes
// - unipolar current scales 0..27648, -4864 under
// - type 0011b two-wire 4-20 mA only
// - type 0100b resistance, never negative counts
// - limit pass on ch0/ch2 raises process interrupt
// - beyond overdrive 7FFFh, below underdrive 8000h (0000h for resistance)
module aipd_top #(
  parameter int T400_CYC = int'(`AIPD_T400_US * `AIPD_CLK_MHZ),
  parameter int T60_CYC = int'(`AIPD_T60_US * `AIPD_CLK_MHZ),
  parameter int T50_CYC = int'(`AIPD_T50_US * `AIPD_CLK_MHZ),
  parameter int T10_CYC = int'(`AIPD_T10_US * `AIPD_CLK_MHZ)
) (
  input wire logic CLK, // module clock
  input wire logic RST, // async reset, high
  input wire logic WR_EN, // record byte write strobe
  input wire logic [3:0] WR_ADDR, // record byte index
  input wire logic [7:0] WR_DATA, // record byte value
  output logic WR_REJECT, // pulse: mode write refused
  input wire logic RD_EN, // record byte read strobe
  input wire logic [3:0] RD_ADDR, // record byte index
  output logic [7:0] RD_DATA, // read byte, next cycle
  output logic DIAG_IRQ_EN, // diagnostic interrupt enabled
  output logic PROC_IRQ_EN, // process interrupt enabled
  output logic [7:0] CONV_SEL, // conversion time codes
  output logic [31:0] PAIR_MODE, // four pair mode bytes
  output logic [3:0] CONV_TICK, // pulse: pair period elapsed
  input wire logic SMP_VALID, // raw sample strobe
  input aipd_pkg::aipd_sample_t SMP, // raw sample
  output logic MEAS_VALID, // pulse: scaled word ready
  output aipd_pkg::aipd_meas_t MEAS, // scaled word
  output logic PROC_IRQ // pulse: limit passed
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // classify a mode byte; anything unlisted is refused
  function automatic aipd_pkg::aipd_kind_t kind_of(input logic [7:0] m);
    logic [3:0] t;
    logic [3:0] r;
    aipd_pkg::aipd_kind_t k;
    t = m[`AIPD_TYPE_LSB +: 4];
    r = m[`AIPD_RANGE_LSB +: 4];
    k = aipd_pkg::AIPD_KIND_BAD;
    case (t)
      `AIPD_TYPE_VOLT:
      begin
        if (r == 4'h7)
          k = aipd_pkg::AIPD_KIND_UNI;
        else if ((r >= 4'h1 && r <= 4'h6) || r == 4'h9)
          k = aipd_pkg::AIPD_KIND_BIP;
      end
      `AIPD_TYPE_CUR4:
      begin
        if (r == 4'h0 || r == 4'h1 || r == 4'h4)
          k = aipd_pkg::AIPD_KIND_BIP;
        else if (r == 4'h2 || r == 4'h3)
          k = aipd_pkg::AIPD_KIND_UNI;
      end
      `AIPD_TYPE_CUR2:
      begin
        if (r == 4'h3)
          k = aipd_pkg::AIPD_KIND_UNI;
      end
      `AIPD_TYPE_RES4:
      begin
        if (r == 4'h2 || r == 4'h4 || r == 4'h6)
          k = aipd_pkg::AIPD_KIND_RES;
      end
      default:
      begin
        k = aipd_pkg::AIPD_KIND_BAD;
      end
    endcase
    return k;
  endfunction

  // cycles of one conversion period for a two-bit code
  function automatic logic [23:0] period_of(input logic [1:0] sel);
    logic [23:0] p;
    case (sel)
      2'b00: p = 24'(T400_CYC);
      2'b01: p = 24'(T60_CYC);
      2'b10: p = 24'(T50_CYC);
      default: p = 24'(T10_CYC);
    endcase
    return p;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  aipd_pkg::aipd_state_t st;
  aipd_pkg::aipd_state_t next_st;

  logic [1:0] pair;
  aipd_pkg::aipd_kind_t kind;
  logic signed [34:0] prod;
  logic signed [19:0] scaled;
  logic signed [19:0] under;
  logic [15:0] value;
  logic lim_ch;
  logic [0:0] lim_idx;
  logic out_now;
  logic [3:0] lk;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.wr_reject = 1'b0;
    next_st.meas_valid = 1'b0;
    next_st.proc_irq = 1'b0;
    next_st.tick = 4'h0;
    lk = 4'h0;

    // record byte writes; index past the record is dropped
    if (WR_EN && WR_ADDR < `AIPD_REC_LEN)
    begin
      if (WR_ADDR == `AIPD_OFF_IRQ)
        next_st.irq_en = WR_DATA & `AIPD_IRQ_MASK;
      else if (WR_ADDR == `AIPD_OFF_CONV)
        next_st.conv = WR_DATA;
      else if (WR_ADDR <= `AIPD_OFF_MODE3)
      begin
        // refused combination keeps the pair's old mode
        if (kind_of(WR_DATA) == aipd_pkg::AIPD_KIND_BAD)
          next_st.wr_reject = 1'b1;
        else
          next_st.mode[2'(WR_ADDR - `AIPD_OFF_MODE0)] = WR_DATA;
      end
      else
      begin
        // limit words: even byte is the high byte
        lk = 4'(WR_ADDR - `AIPD_OFF_LIM0_UP) >> 1;
        if (WR_ADDR[0] == 1'b0)
          next_st.lim[lk[1:0]][15:8] = WR_DATA;
        else
          next_st.lim[lk[1:0]][7:0] = WR_DATA;
      end
    end

    // register read-back, one cycle late
    if (RD_EN)
    begin
      if (RD_ADDR == `AIPD_OFF_IRQ)
        next_st.rd_data = st.irq_en;
      else if (RD_ADDR == `AIPD_OFF_CONV)
        next_st.rd_data = st.conv;
      else if (RD_ADDR <= `AIPD_OFF_MODE3)
        next_st.rd_data = st.mode[2'(RD_ADDR - `AIPD_OFF_MODE0)];
      else if (RD_ADDR < `AIPD_REC_LEN)
      begin
        lk = 4'(RD_ADDR - `AIPD_OFF_LIM0_UP) >> 1;
        next_st.rd_data = RD_ADDR[0] ? st.lim[lk[1:0]][7:0] : st.lim[lk[1:0]][15:8];
      end
      else
        next_st.rd_data = 8'h00;
    end

    // per-pair conversion period counters
    for (int i = 0; i < 4; i++)
    begin
      if (st.cnt[i] >= period_of(st.conv[2*i +: 2]) - 24'h000001)
      begin
        next_st.cnt[i] = 24'h000000;
        next_st.tick[i] = 1'b1;
      end
      else
        next_st.cnt[i] = st.cnt[i] + 24'h000001;
    end

    // scaling of one sample to its count word
    pair = SMP.ch[2:1];
    kind = kind_of(st.mode[pair]);
    prod = 35'(SMP.raw) * $signed({19'h00000, `AIPD_NOM_CNT});
    scaled = {prod[34], prod[34:16]};
    case (kind)
      aipd_pkg::AIPD_KIND_UNI: under = `AIPD_UND_UNI;
      aipd_pkg::AIPD_KIND_RES: under = 20'sd0;
      default: under = `AIPD_UND_BIP;
    endcase
    if (scaled > `AIPD_OVR_END)
      value = `AIPD_SAT_HI;
    else if (scaled < under)
      value = (kind == aipd_pkg::AIPD_KIND_RES) ? 16'h0000 : `AIPD_SAT_LO;
    else
      value = scaled[15:0];

    // limit watch on channels 0 and 2 only
    lim_ch = (SMP.ch == 3'h0) || (SMP.ch == 3'h2);
    lim_idx = SMP.ch[1];
    out_now = ($signed(value) > $signed(st.lim[{lim_idx, 1'b0}])) ||
              ($signed(value) < $signed(st.lim[{lim_idx, 1'b1}]));

    if (SMP_VALID)
    begin
      next_st.meas_valid = 1'b1;
      next_st.meas.ch = SMP.ch;
      next_st.meas.value = value;
      if (lim_ch)
      begin
        // fire only on entering the out-of-limit state
        next_st.outside[lim_idx] = out_now;
        if (out_now && !st.outside[lim_idx] && st.irq_en[`AIPD_PROC_BIT])
          next_st.proc_irq = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st <= '0;
      st.irq_en <= `AIPD_RST_IRQ;
      st.conv <= `AIPD_RST_CONV;
      st.mode <= {4{`AIPD_RST_MODE}};
      st.lim <= {`AIPD_RST_LO, `AIPD_RST_UP, `AIPD_RST_LO, `AIPD_RST_UP};
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign WR_REJECT = st.wr_reject;
  assign RD_DATA = st.rd_data;
  assign DIAG_IRQ_EN = st.irq_en[`AIPD_DIAG_BIT];
  assign PROC_IRQ_EN = st.irq_en[`AIPD_PROC_BIT];
  assign CONV_SEL = st.conv;
  assign PAIR_MODE = st.mode;
  assign CONV_TICK = st.tick;
  assign MEAS_VALID = st.meas_valid;
  assign MEAS = st.meas;
  assign PROC_IRQ = st.proc_irq;

endmodule

// ---- tb/aipd_props.sv ----
`timescale 1ns/1ps
module aipd_props (
  input wire logic CLK, // clock
  input wire logic RST, // reset
  input wire logic WR_EN, // write
  input wire logic [3:0] WR_ADDR, // index
  input wire logic [7:0] WR_DATA, // byte
  input wire logic WR_REJECT, // refused
  input wire logic RD_EN, // read
  input wire logic [3:0] RD_ADDR, // index
  input wire logic [7:0] RD_DATA, // byte
  input wire logic DIAG_IRQ_EN, // diag enable
  input wire logic PROC_IRQ_EN, // proc enable
  input wire logic [7:0] CONV_SEL, // conv codes
  input wire logic [31:0] PAIR_MODE, // modes
  input wire logic [3:0] CONV_TICK, // ticks
  input wire logic SMP_VALID, // sample strobe
  input aipd_pkg::aipd_sample_t SMP, // sample
  input wire logic MEAS_VALID, // word ready
  input aipd_pkg::aipd_meas_t MEAS, // word
  input wire logic PROC_IRQ // limit event
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // -----------------------------------
  // register and sample path
  // -----------------------------------
  sequence s_bad_mode;
    WR_EN && WR_ADDR == 4'h2 && WR_DATA == 8'hFF;
  endsequence
  sequence s_pulse;
    WR_REJECT ##1 !WR_REJECT;
  endsequence
  a_bad_reject: assert property (s_bad_mode |=> s_pulse) else $error("bad mode kept");
  a_reject_cause: assert property (WR_REJECT |-> $past(WR_EN) && $past(WR_ADDR) inside {[4'h2:4'h5]})
    else $error("stray reject");
  a_irq_bits: assert property (WR_EN && WR_ADDR == 4'h0 |=> {PROC_IRQ_EN, DIAG_IRQ_EN} == $past(WR_DATA[7:6]))
    else $error("enable bits wrong");
  a_conv_store: assert property (WR_EN && WR_ADDR == 4'h1 |=> CONV_SEL == $past(WR_DATA))
    else $error("conv byte wrong");
  a_meas_follow: assert property (SMP_VALID |=> MEAS_VALID && MEAS.ch == $past(SMP.ch))
    else $error("no word after sample");
  a_sat_high: assert property (SMP_VALID && SMP.raw == 18'sh1FFFF |=> MEAS.value == 16'h7FFF)
    else $error("no high clamp");
  a_sat_low: assert property (SMP_VALID && SMP.raw == 18'sh20000 && PAIR_MODE[8*SMP.ch[2:1]+4 +: 4] != 4'h4
    |=> MEAS.value == 16'h8000) else $error("no low clamp");
  a_res_floor: assert property (SMP_VALID && SMP.raw == 18'sh20000 && PAIR_MODE[8*SMP.ch[2:1]+4 +: 4] == 4'h4
    |=> MEAS.value == 16'h0000) else $error("negative resistance");
  a_irq_gate: assert property (PROC_IRQ |-> MEAS_VALID && $past(PROC_IRQ_EN)) else $error("ungated irq");
  a_rd_unmapped: assert property (RD_EN && RD_ADDR >= 4'hE |=> RD_DATA == 8'h00) else $error("gap read");
  // pair 0 at code 10b ticks every 9 cycles with the bench's short periods; a code change excuses the window
  a_tick_period: assert property (CONV_TICK[0] && CONV_SEL[1:0] == 2'b10 |=>
    (!CONV_TICK[0] [*8] ##1 CONV_TICK[0]) or (##[0:8] $changed(CONV_SEL))) else $error("tick period wrong");
endmodule

// ---- tb/aipd_cpu.sv ----
`timescale 1ns/1ps
// controller side: one byte access per call, idle cycle between
module aipd_cpu (
  input wire logic clk, // clock
  output logic wr_en, // write strobe
  output logic [3:0] wr_addr, // byte index
  output logic [7:0] wr_data, // byte value
  output logic rd_en, // read strobe
  output logic [3:0] rd_addr // byte index
);
  initial
  begin
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 8'h00;
    rd_en = 1'b0;
    rd_addr = 4'h0;
  end
  // released lines show inverted data so stale values never match
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en, wr_reject, rd_en, diag_en, proc_en, meas_valid, proc_irq;
  logic smp_valid = 1'b0;
  logic [3:0] wr_addr, rd_addr, conv_tick, p;
  logic [7:0] wr_data, rd_data, conv_sel;
  logic [31:0] pair_mode, r;
  aipd_pkg::aipd_sample_t smp_d = '0;
  aipd_pkg::aipd_meas_t meas;
  int fails = 0;
  int num_checks = 0;
  int irqs = 0;
  logic rd_pend = 1'b0;
  logic [7:0] rq[$];
  logic [15:0] mq[$];
  logic [7:0] rv[16] = '{8'h00, 8'hAA, 8'h19, 8'h19, 8'h19, 8'h19, 8'h7F, 8'hFF, 8'h80, 8'h00, 8'h7F, 8'hFF,
    8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] md[17] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h19, 8'h17, 8'h20, 8'h21, 8'h24, 8'h22,
    8'h23, 8'h33, 8'h42, 8'h44, 8'h46};
  logic signed [17:0] sv[4] = '{18'sd65536, -18'sd65536, 18'sh1FFFF, 18'sh20000};
  always #4 clk = ~clk;
  aipd_cpu aipd_cpu_i (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr));
  // short periods keep the tick counters cheap to run
  aipd_top #(.T400_CYC(5), .T60_CYC(7), .T50_CYC(9), .T10_CYC(11)) aipd_top_i (.CLK(clk), .RST(rst),
    .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_REJECT(wr_reject), .RD_EN(rd_en),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data), .DIAG_IRQ_EN(diag_en), .PROC_IRQ_EN(proc_en), .CONV_SEL(conv_sel),
    .PAIR_MODE(pair_mode), .CONV_TICK(conv_tick), .SMP_VALID(smp_valid), .SMP(smp_d),
    .MEAS_VALID(meas_valid), .MEAS(meas), .PROC_IRQ(proc_irq));
  // -----------------------------------
  // checking
  // -----------------------------------
  task test_done;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
      fails++;
    end
  endtask
  // sampled mid-cycle, after the launching edge has settled
  always @(negedge clk)
  begin
    if (rd_pend)
      chk({8'h00, rd_data}, rq.pop_front());
    rd_pend = rd_en;
    if (meas_valid === 1'b1)
      chk(meas.value, mq.pop_front());
    if (proc_irq === 1'b1)
      irqs++;
  end
  task rdx(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    aipd_cpu_i.rd(a);
  endtask
  // k: 0 bipolar, 1 unipolar, 2 resistance
  task smp(input logic [2:0] c, input logic signed [17:0] v, input int k);
    logic signed [35:0] q;
    q = (v * 36'sd27648) >>> 16;
    if (q > 32511)
      q = 32767;
    else if (k == 2 && q < 0)
      q = 0;
    else if (q < (k == 0 ? -32512 : -4864))
      q = -32768;
    mq.push_back(q[15:0]);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_d <= {c, v};
    @(posedge clk);
    smp_valid <= 1'b0;
    smp_d <= ~{c, v};
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    r = $urandom(32'h0ed5cfea);
    for (int i = 0; i < 16; i++)
      rdx(4'(i), rv[i]);
    $display("test reset done");
    aipd_cpu_i.wr(4'h0, 8'hFF);
    rdx(4'h0, 8'hC0);
    r = $urandom;
    aipd_cpu_i.wr(4'h1, r[7:0]);
    rdx(4'h1, r[7:0]);
    for (int i = 6; i < 14; i++)
    begin
      r = $urandom;
      aipd_cpu_i.wr(4'(i), r[7:0]);
      rdx(4'(i), r[7:0]);
    end
    $display("test bytes done");
    for (int i = 0; i < 17; i++)
    begin
      p = 4'(2 + $urandom % 4);
      aipd_cpu_i.wr(p, md[i]);
      rdx(p, md[i]);
      r = $urandom;
      for (int j = 0; j < 5; j++)
        smp({2'(p - 4'h2), r[0]}, j < 4 ? sv[j] : r[18:1], md[i][7:4] == 4'h4 ? 2 : (md[i] inside {8'h17, 8'h22,
          8'h23, 8'h33} ? 1 : 0));
    end
    $display("test scaling done");
    aipd_cpu_i.wr(4'h2, 8'h19);
    aipd_cpu_i.wr(4'h2, 8'hFF);
    aipd_cpu_i.wr(4'h2, 8'h18);
    rdx(4'h2, 8'h19);
    $display("test refuse done");
    aipd_cpu_i.wr(4'h0, 8'h00);
    aipd_cpu_i.wr(4'h6, 8'h10);
    aipd_cpu_i.wr(4'h7, 8'h00);
    aipd_cpu_i.wr(4'h8, 8'hF0);
    aipd_cpu_i.wr(4'h9, 8'h00);
    smp(3'h0, 18'sd0, 0);
    smp(3'h0, 18'sd65536, 0);
    smp(3'h0, 18'sd0, 0);
    aipd_cpu_i.wr(4'h0, 8'h80);
    irqs = 0;
    smp(3'h0, 18'sd65536, 0);
    smp(3'h0, 18'sd65536, 0);
    smp(3'h1, -18'sd65536, 0);
    // back inside first: the interrupt fires only on entry to the outside state
    smp(3'h0, 18'sd0, 0);
    smp(3'h0, -18'sd65536, 0);
    repeat (2) @(posedge clk);
    chk(16'(irqs), 16'h0002);
    $display("test limit done");
    chk(16'(rq.size() + mq.size()), 16'h0000);
    test_done();
  end
endmodule
bind aipd_top aipd_props aipd_props_i (.CLK, .RST, .WR_EN, .WR_ADDR, .WR_DATA, .WR_REJECT, .RD_EN, .RD_ADDR,
  .RD_DATA, .DIAG_IRQ_EN, .PROC_IRQ_EN, .CONV_SEL, .PAIR_MODE, .CONV_TICK, .SMP_VALID, .SMP, .MEAS_VALID, .MEAS,
  .PROC_IRQ);
